// [rtl/mct_instr_timing.sv]
// Purpose: Decodes length and clock count of each instruction, sequences
//          its execution clocks and resolves branches and operand targets.
// Assumes: Opcode, operand bytes and datapath values come from logic on
//          the same clock, valid while instr_valid is high.
// Notes: One instruction at a time; accepted only while instr_ready.
`timescale 1ns/1ps
`include "mct_params.svh"
module mct_instr_timing (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [7:0] instr_opcode,
    input wire logic [7:0] instr_b1,
    input wire logic [7:0] instr_b2,
    input wire logic [15:0] instr_pc,
    input wire logic [7:0] acc_val,
    input wire logic [15:0] data_ptr_val,
    input wire logic [7:0] status_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] dir_val,
    input wire logic [7:0] ptr_val,
    input wire logic bit_val,
    input wire logic [15:0] return_addr,
    output logic instr_ready,
    output logic instr_done,
    output logic [1:0] instr_len,
    output logic [3:0] instr_cycles,
    output logic br_taken,
    output logic [15:0] next_pc,
    output logic code_rd,
    output logic [15:0] code_addr,
    output logic xdata_rd,
    output logic xdata_wr,
    output logic [15:0] xdata_addr,
    output logic dir_special,
    output logic [4:0] reg_addr,
    output logic [4:0] ptr_addr,
    output logic acc_we,
    output logic [7:0] acc_res,
    output logic carry_we,
    output logic carry_res,
    output logic ram_we,
    output logic [7:0] ram_res,
    output logic bit_clr
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    mct_if ifc();
    mct_pkg::mct_tcls_t tcls;
    mct_pkg::mct_kind_t kind;
    mct_pkg::mct_state_t state_reg;
    logic [1:0] len;
    logic [3:0] cyc_nt;
    logic [3:0] cyc_tk;
    logic [3:0] cyc_sel;
    logic [3:0] cnt_reg;
    logic [15:0] pc_next;
    logic [15:0] tgt;
    logic [7:0] cmp_r;
    logic [7:0] cmp_l;
    logic taken;
    logic accept;
    logic last;
    logic ready_reg;
    logic done_reg;

    assign accept = (state_reg == mct_pkg::MCT_IDLE) && instr_valid;
    assign last = (state_reg == mct_pkg::MCT_EXEC) && (cnt_reg == `MCT_CNT_LAST);

    // ----------------------------------------
    // Opcode decode
    // ----------------------------------------
    // Encodings follow the standard set bit for bit; only timing is ours
    always_comb begin
        tcls = mct_pkg::MCT_K11;
        kind = mct_pkg::MCT_NONE;
        casez (instr_opcode)
            8'h00, 8'ha5: tcls = mct_pkg::MCT_K11;
            8'h02: begin tcls = mct_pkg::MCT_K34; kind = mct_pkg::MCT_LONGJ; end
            8'h12: begin tcls = mct_pkg::MCT_K34; kind = mct_pkg::MCT_LONGC; end
            8'h22, 8'h32: begin tcls = mct_pkg::MCT_K15; kind = mct_pkg::MCT_RTN; end
            8'h03: kind = mct_pkg::MCT_RR;
            8'h13: kind = mct_pkg::MCT_RRC;
            8'h23: kind = mct_pkg::MCT_RL;
            8'h33: kind = mct_pkg::MCT_RLC;
            8'hc4: kind = mct_pkg::MCT_SWAP;
            8'he4: kind = mct_pkg::MCT_ACLR;
            8'hf4: kind = mct_pkg::MCT_ACPL;
            8'hc3: kind = mct_pkg::MCT_CCLR;
            8'hd3: kind = mct_pkg::MCT_CSET;
            8'hb3: kind = mct_pkg::MCT_CCPL;
            8'h04, 8'h14, 8'ha3, 8'hd4: tcls = mct_pkg::MCT_K11;
            8'h84: tcls = mct_pkg::MCT_K18;
            8'ha4: tcls = mct_pkg::MCT_K14;
            8'h10: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_BTCJ; end
            8'h20: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_JB; end
            8'h30: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_JNB; end
            8'h40: begin tcls = mct_pkg::MCT_B223; kind = mct_pkg::MCT_JC; end
            8'h50: begin tcls = mct_pkg::MCT_B223; kind = mct_pkg::MCT_JNC; end
            8'h60: begin tcls = mct_pkg::MCT_B223; kind = mct_pkg::MCT_JZ; end
            8'h70: begin tcls = mct_pkg::MCT_B223; kind = mct_pkg::MCT_JNZ; end
            8'h80: begin tcls = mct_pkg::MCT_K23; kind = mct_pkg::MCT_SHRTJ; end
            8'h73: begin tcls = mct_pkg::MCT_K13; kind = mct_pkg::MCT_JMPI; end
            8'h83: begin tcls = mct_pkg::MCT_K13; kind = mct_pkg::MCT_MOVCP; end
            8'h93: begin tcls = mct_pkg::MCT_K13; kind = mct_pkg::MCT_MOVCD; end
            8'h43, 8'h53, 8'h63, 8'h75, 8'h85: tcls = mct_pkg::MCT_K33;
            8'h90: tcls = mct_pkg::MCT_K33;
            8'hb4, 8'hb5: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_CJA; end
            8'hd5: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_DECJ; end
            8'he0, 8'he2, 8'he3: begin
                tcls = mct_pkg::MCT_K13;
                kind = mct_pkg::MCT_XRD;
            end
            8'hf0, 8'hf2, 8'hf3: begin
                tcls = mct_pkg::MCT_K13;
                kind = mct_pkg::MCT_XWR;
            end
            8'b???0_0001: begin tcls = mct_pkg::MCT_K23; kind = mct_pkg::MCT_PAGEJ; end
            8'b???1_0001: begin tcls = mct_pkg::MCT_K23; kind = mct_pkg::MCT_PAGEC; end
            8'b1011_1???: begin tcls = mct_pkg::MCT_B334; kind = mct_pkg::MCT_CJS; end
            8'b1101_1???: begin tcls = mct_pkg::MCT_B223; kind = mct_pkg::MCT_DECJ; end
            8'b0111_1???, 8'b1000_1???, 8'b1010_1???: tcls = mct_pkg::MCT_K22;
            8'b????_1???: tcls = mct_pkg::MCT_K11;
            8'b1011_011?: begin tcls = mct_pkg::MCT_B345; kind = mct_pkg::MCT_CJS; end
            8'b1101_011?: begin tcls = mct_pkg::MCT_K12; kind = mct_pkg::MCT_NIBX; end
            8'b0111_011?, 8'b1000_011?, 8'b1010_011?: tcls = mct_pkg::MCT_K22;
            8'b????_011?: tcls = mct_pkg::MCT_K12;
            // Remaining direct, bit, immediate, push and pop forms
            8'b????_0???: tcls = mct_pkg::MCT_K22;
            default: tcls = mct_pkg::MCT_K11;
        endcase
    end

    // ----------------------------------------
    // Length and clocks of each timing class
    // ----------------------------------------
    always_comb begin
        len = `MCT_LEN1;
        cyc_nt = `MCT_CYC1;
        case (tcls)
            mct_pkg::MCT_K11: cyc_nt = `MCT_CYC1;
            mct_pkg::MCT_K12: cyc_nt = `MCT_CYC2;
            mct_pkg::MCT_K22: begin len = `MCT_LEN2; cyc_nt = `MCT_CYC2; end
            mct_pkg::MCT_K33: begin len = `MCT_LEN3; cyc_nt = `MCT_CYC3; end
            mct_pkg::MCT_K13: cyc_nt = `MCT_CYC3;
            mct_pkg::MCT_K23: begin len = `MCT_LEN2; cyc_nt = `MCT_CYC3; end
            mct_pkg::MCT_K34: begin len = `MCT_LEN3; cyc_nt = `MCT_CYC4; end
            mct_pkg::MCT_K14: cyc_nt = `MCT_CYC4;
            mct_pkg::MCT_K15: cyc_nt = `MCT_CYC5;
            mct_pkg::MCT_K18: cyc_nt = `MCT_CYC8;
            mct_pkg::MCT_B223: begin len = `MCT_LEN2; cyc_nt = `MCT_CYC2; end
            mct_pkg::MCT_B334: begin len = `MCT_LEN3; cyc_nt = `MCT_CYC3; end
            mct_pkg::MCT_B345: begin len = `MCT_LEN3; cyc_nt = `MCT_CYC4; end
            default: cyc_nt = `MCT_CYC1;
        endcase
    end

    // Conditional classes take one clock more when taken
    assign cyc_tk = (tcls == mct_pkg::MCT_B223 || tcls == mct_pkg::MCT_B334 ||
                     tcls == mct_pkg::MCT_B345) ? cyc_nt + `MCT_CYC1 : cyc_nt;
    assign cyc_sel = taken ? cyc_tk : cyc_nt;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    assign pc_next = instr_pc + {14'h0000, len};
    assign ifc.opcode = instr_opcode;
    assign ifc.b1 = instr_b1;
    assign ifc.b2 = instr_b2;
    assign ifc.acc = acc_val;
    assign ifc.src_val = src_val;
    assign ifc.data_ptr = data_ptr_val;
    assign ifc.pc_next = pc_next;
    assign ifc.bank = {status_val[`MCT_BANK_HI], status_val[`MCT_BANK_LO]};
    assign ifc.carry = status_val[`MCT_MSB];
    assign ifc.len3 = (len == `MCT_LEN3);
    assign ifc.kind = kind;

    mct_target u_target (
        .t(ifc.tgt)
    );

    mct_accop u_accop (
        .a(ifc.alu)
    );

    // ----------------------------------------
    // Branch decision and target
    // ----------------------------------------
    assign cmp_l = (kind == mct_pkg::MCT_CJA) ? acc_val : src_val;
    assign cmp_r = (instr_opcode == 8'hb5) ? dir_val : instr_b1;

    always_comb begin
        taken = 1'b0;
        tgt = pc_next;
        case (kind)
            mct_pkg::MCT_JC: taken = ifc.carry;
            mct_pkg::MCT_JNC: taken = ~ifc.carry;
            mct_pkg::MCT_JZ: taken = (acc_val == `MCT_B0);
            mct_pkg::MCT_JNZ: taken = (acc_val != `MCT_B0);
            mct_pkg::MCT_JB, mct_pkg::MCT_BTCJ: taken = bit_val;
            mct_pkg::MCT_JNB: taken = ~bit_val;
            mct_pkg::MCT_CJA, mct_pkg::MCT_CJS: taken = (cmp_l != cmp_r);
            mct_pkg::MCT_DECJ: taken = (src_val != `MCT_B1);
            mct_pkg::MCT_SHRTJ, mct_pkg::MCT_PAGEJ, mct_pkg::MCT_PAGEC,
            mct_pkg::MCT_LONGJ, mct_pkg::MCT_LONGC, mct_pkg::MCT_JMPI,
            mct_pkg::MCT_RTN: taken = 1'b1;
            default: taken = 1'b0;
        endcase
        case (kind)
            mct_pkg::MCT_PAGEJ, mct_pkg::MCT_PAGEC: tgt = ifc.page_tgt;
            mct_pkg::MCT_LONGJ, mct_pkg::MCT_LONGC: tgt = {instr_b1, instr_b2};
            mct_pkg::MCT_JMPI: tgt = ifc.code_dp;
            mct_pkg::MCT_RTN: tgt = return_addr;
            default: tgt = taken ? ifc.rel_tgt : pc_next;
        endcase
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    // Counting runs on every system clock; there is no machine-cycle divider
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= mct_pkg::MCT_IDLE;
        end else begin
            case (state_reg)
                mct_pkg::MCT_IDLE: if (instr_valid) state_reg <= mct_pkg::MCT_EXEC;
                mct_pkg::MCT_EXEC: if (last) state_reg <= mct_pkg::MCT_IDLE;
                default: state_reg <= mct_pkg::MCT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= `MCT_CNT_LAST;
        end else if (accept) begin
            cnt_reg <= cyc_sel - `MCT_CYC1;
        end else if (state_reg == mct_pkg::MCT_EXEC && !last) begin
            cnt_reg <= cnt_reg - `MCT_CYC1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
        end else begin
            done_reg <= last;
            if (accept) begin
                ready_reg <= 1'b0;
            end else if (last) begin
                ready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Instruction results
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            instr_len <= `MCT_LEN1;
            instr_cycles <= `MCT_CYC1;
            br_taken <= 1'b0;
            next_pc <= `MCT_PC_RST;
            code_addr <= `MCT_W0;
            xdata_addr <= `MCT_W0;
            dir_special <= 1'b0;
            reg_addr <= `MCT_A0;
            ptr_addr <= `MCT_A0;
            acc_res <= `MCT_B0;
            carry_res <= 1'b0;
            ram_res <= `MCT_B0;
        end else if (accept) begin
            instr_len <= len;
            instr_cycles <= cyc_sel;
            br_taken <= taken;
            next_pc <= tgt;
            code_addr <= (kind == mct_pkg::MCT_MOVCP) ? ifc.code_pc : ifc.code_dp;
            // Xdata opcodes other than e0 and f0 carry an 8-bit pointer held in R0 or R1
            xdata_addr <= instr_opcode[`MCT_RSEL] == 3'h0 ? data_ptr_val
                : {`MCT_B0, ptr_val};
            dir_special <= instr_b1[`MCT_SPACE_BIT];
            reg_addr <= ifc.reg_addr;
            ptr_addr <= ifc.ptr_addr;
            acc_res <= ifc.acc_res;
            carry_res <= (kind == mct_pkg::MCT_CJA || kind == mct_pkg::MCT_CJS)
                ? (cmp_l < cmp_r) : ifc.carry_res;
            ram_res <= (kind == mct_pkg::MCT_DECJ) ? src_val - `MCT_B1
                : ifc.ram_res;
        end
    end

    // Strobes stand through the execution clocks and drop with the last
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            code_rd <= 1'b0;
            xdata_rd <= 1'b0;
            xdata_wr <= 1'b0;
            acc_we <= 1'b0;
            carry_we <= 1'b0;
            ram_we <= 1'b0;
            bit_clr <= 1'b0;
        end else if (accept) begin
            code_rd <= kind == mct_pkg::MCT_MOVCP || kind == mct_pkg::MCT_MOVCD;
            xdata_rd <= kind == mct_pkg::MCT_XRD;
            xdata_wr <= kind == mct_pkg::MCT_XWR;
            acc_we <= kind >= mct_pkg::MCT_ACLR && kind <= mct_pkg::MCT_NIBX;
            carry_we <= kind == mct_pkg::MCT_RLC || kind == mct_pkg::MCT_RRC
                || kind >= mct_pkg::MCT_CCLR || kind == mct_pkg::MCT_CJA
                || kind == mct_pkg::MCT_CJS;
            ram_we <= kind == mct_pkg::MCT_NIBX || kind == mct_pkg::MCT_DECJ;
            bit_clr <= kind == mct_pkg::MCT_BTCJ && bit_val;
        end else if (last) begin
            code_rd <= 1'b0;
            xdata_rd <= 1'b0;
            xdata_wr <= 1'b0;
            acc_we <= 1'b0;
            carry_we <= 1'b0;
            ram_we <= 1'b0;
            bit_clr <= 1'b0;
        end
    end

    assign instr_ready = ready_reg;
    assign instr_done = done_reg;
endmodule

// [inc/mct_params.svh]
// Purpose: Constants for the instruction length and timing block.
// Assumes: Included by bare name; one system clock at 10 MHz.
// Notes: Lengths in bytes, counts in system clocks.
`ifndef MCT_PARAMS_SVH
`define MCT_PARAMS_SVH

// ----------------------------------------
// Instruction lengths and clock counts
// ----------------------------------------
`define MCT_LEN1 2'h1
`define MCT_LEN2 2'h2
`define MCT_LEN3 2'h3
`define MCT_CYC1 4'h1
`define MCT_CYC2 4'h2
`define MCT_CYC3 4'h3
`define MCT_CYC4 4'h4
`define MCT_CYC5 4'h5
`define MCT_CYC8 4'h8
`define MCT_CNT_LAST 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCT_BANK_HI 4
`define MCT_BANK_LO 3
`define MCT_SPACE_BIT 7
`define MCT_MSB 7
`define MCT_LSB 0
`define MCT_HI7 7:1
`define MCT_LO7 6:0
`define MCT_NHI 7:4
`define MCT_NLO 3:0
`define MCT_PAGE 15:11
`define MCT_AHI 7:5
`define MCT_RSEL 2:0
`define MCT_PSEL 0
`define MCT_SX 8

// ----------------------------------------
// Values
// ----------------------------------------
`define MCT_PTR_HI 2'h0
`define MCT_B0 8'h00
`define MCT_B1 8'h01
`define MCT_W0 16'h0000
`define MCT_A0 5'h00
`define MCT_PC_RST 16'h0000

`endif

// [inc/mct_pkg.sv]
// Purpose: Types shared by the instruction timing modules.
// Assumes: Constants come from mct_params.svh.
// Notes: Nothing here is imported; users write mct_pkg::name.
package mct_pkg;

    // Timing class: bytes, clocks not taken, clocks taken
    typedef enum logic [3:0] {
        MCT_K11, MCT_K12, MCT_K22, MCT_K33, MCT_K13, MCT_K23, MCT_K34,
        MCT_K14, MCT_K15, MCT_K18, MCT_B223, MCT_B334, MCT_B345
    } mct_tcls_t;

    typedef enum logic [5:0] {
        MCT_NONE, MCT_JC, MCT_JNC, MCT_JB, MCT_JNB, MCT_BTCJ, MCT_JZ, MCT_JNZ,
        MCT_CJA, MCT_CJS, MCT_DECJ, MCT_SHRTJ, MCT_PAGEJ, MCT_PAGEC, MCT_LONGJ,
        MCT_LONGC, MCT_JMPI, MCT_RTN, MCT_MOVCP, MCT_MOVCD, MCT_XRD, MCT_XWR,
        MCT_ACLR, MCT_ACPL, MCT_RL, MCT_RLC, MCT_RR, MCT_RRC, MCT_SWAP,
        MCT_NIBX, MCT_CCLR, MCT_CSET, MCT_CCPL
    } mct_kind_t;

    typedef enum logic {MCT_IDLE, MCT_EXEC} mct_state_t;

endpackage

// [inc/mct_if.sv]
// Purpose: Carries decoded fields between the core and its helpers.
// Assumes: Single clock domain, purely combinational paths.
// Notes: The core drives operands, helpers return results.
`timescale 1ns/1ps
interface mct_if;
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] acc;
    logic [7:0] src_val;
    logic [15:0] data_ptr;
    logic [15:0] pc_next;
    logic [1:0] bank;
    logic carry;
    logic len3;
    mct_pkg::mct_kind_t kind;
    logic [15:0] rel_tgt;
    logic [15:0] page_tgt;
    logic [15:0] code_pc;
    logic [15:0] code_dp;
    logic [4:0] reg_addr;
    logic [4:0] ptr_addr;
    logic [7:0] acc_res;
    logic [7:0] ram_res;
    logic carry_res;

    modport core (output opcode, b1, b2, acc, src_val, data_ptr, pc_next, bank,
        carry, len3, kind, input rel_tgt, page_tgt, code_pc, code_dp,
        reg_addr, ptr_addr, acc_res, ram_res, carry_res);
    modport tgt (input opcode, b1, b2, acc, data_ptr, pc_next, bank, len3,
        output rel_tgt, page_tgt, code_pc, code_dp, reg_addr, ptr_addr);
    modport alu (input kind, acc, carry, src_val,
        output acc_res, ram_res, carry_res);
endinterface

// [rtl/mct_target.sv]
// Purpose: Operand address and branch target arithmetic.
// Assumes: pc_next is the address of the following instruction.
// Notes: Pure combinational logic.
`timescale 1ns/1ps
`include "mct_params.svh"
module mct_target (
    mct_if.tgt t
);
    logic [7:0] rel;

    assign rel = t.len3 ? t.b2 : t.b1;
    assign t.rel_tgt = t.pc_next + {{`MCT_SX{rel[`MCT_MSB]}}, rel};
    // Upper bits of pc_next kept, so the target stays in the page of the following instruction
    assign t.page_tgt = {t.pc_next[`MCT_PAGE], t.opcode[`MCT_AHI], t.b1};
    assign t.code_pc = t.pc_next + {`MCT_B0, t.acc};
    assign t.code_dp = t.data_ptr + {`MCT_B0, t.acc};
    assign t.reg_addr = {t.bank, t.opcode[`MCT_RSEL]};
    assign t.ptr_addr = {t.bank, `MCT_PTR_HI, t.opcode[`MCT_PSEL]};
endmodule

// [rtl/mct_accop.sv]
// Purpose: Accumulator, nibble and carry results of one instruction.
// Assumes: acc, carry and src_val are the values before execution.
// Notes: Pure combinational logic.
`timescale 1ns/1ps
`include "mct_params.svh"
module mct_accop (
    mct_if.alu a
);
    always_comb begin
        a.acc_res = a.acc;
        a.ram_res = a.src_val;
        a.carry_res = a.carry;
        case (a.kind)
            mct_pkg::MCT_ACLR: a.acc_res = `MCT_B0;
            mct_pkg::MCT_ACPL: a.acc_res = ~a.acc;
            mct_pkg::MCT_RL: a.acc_res = {a.acc[`MCT_LO7], a.acc[`MCT_MSB]};
            mct_pkg::MCT_RLC: begin
                a.acc_res = {a.acc[`MCT_LO7], a.carry};
                a.carry_res = a.acc[`MCT_MSB];
            end
            mct_pkg::MCT_RR: a.acc_res = {a.acc[`MCT_LSB], a.acc[`MCT_HI7]};
            mct_pkg::MCT_RRC: begin
                a.acc_res = {a.carry, a.acc[`MCT_HI7]};
                a.carry_res = a.acc[`MCT_LSB];
            end
            mct_pkg::MCT_SWAP: a.acc_res = {a.acc[`MCT_NLO], a.acc[`MCT_NHI]};
            mct_pkg::MCT_NIBX: begin
                a.acc_res = {a.acc[`MCT_NHI], a.src_val[`MCT_NLO]};
                a.ram_res = {a.src_val[`MCT_NHI], a.acc[`MCT_NLO]};
            end
            mct_pkg::MCT_CCLR: a.carry_res = 1'b0;
            mct_pkg::MCT_CSET: a.carry_res = 1'b1;
            mct_pkg::MCT_CCPL: a.carry_res = ~a.carry;
            default: a.carry_res = a.carry;
        endcase
    end
endmodule

// [test/mct_mem_model.sv]
// Purpose: Memory side: data RAM, pointer registers, bit space and stack.
// Assumes: Contents are fixed patterns of the operand byte.
// Notes: Combinational, so values are valid when a request is taken.
`timescale 1ns/1ps
module mct_mem_model (
    input wire logic [7:0] instr_b1,
    output logic [7:0] src_val,
    output logic [7:0] dir_val,
    output logic [7:0] ptr_val,
    output logic bit_val,
    output logic [15:0] return_addr
);
    assign src_val = instr_b1 ^ 8'h5a;
    assign dir_val = instr_b1 ^ 8'ha5;
    assign ptr_val = instr_b1 + 8'h01;
    assign bit_val = instr_b1[0];
    // Stack top: pattern lets the bench know the popped address
    assign return_addr = {instr_b1, 8'h3c};
endmodule

// [test/mct_monitor.sv]
// Purpose: Port checks of instruction timing and targets.
// Assumes: Bound to mct_instr_timing.
// Notes: All counts in system clocks.
`timescale 1ns/1ps
module mct_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [7:0] instr_opcode,
    input wire logic [7:0] instr_b1,
    input wire logic [15:0] instr_pc,
    input wire logic [15:0] data_ptr_val,
    input wire logic [7:0] status_val,
    input wire logic [15:0] return_addr,
    input wire logic instr_ready,
    input wire logic instr_done,
    input wire logic [3:0] instr_cycles,
    input wire logic br_taken,
    input wire logic [15:0] next_pc,
    input wire logic xdata_rd,
    input wire logic [15:0] xdata_addr,
    input wire logic acc_we
);
    logic [3:0] cnt_reg;
    logic [15:0] pc2;
    assign pc2 = instr_pc + 16'h0002;
    // Busy clocks since the last accept
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= 4'h0;
        end else if (instr_ready && instr_valid) begin
            cnt_reg <= 4'h0;
        end else if (!instr_ready) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_take(logic [7:0] op);
        instr_ready && instr_valid && instr_opcode == op;
    endsequence
    property p_count; instr_done |-> cnt_reg == instr_cycles; endproperty
    a_count: assert property (p_count) else $error("busy length differs");
    property p_xrd; s_take(8'he0) |=> xdata_rd && xdata_addr == $past(data_ptr_val); endproperty
    a_xrd: assert property (p_xrd) else $error("external read wrong");
    property p_clra; s_take(8'he4) |=> instr_cycles == 4'h1 && acc_we; endproperty
    a_clra: assert property (p_clra) else $error("accumulator op wrong");
    property p_ret; s_take(8'h22) |=> instr_cycles == 4'h5
        && next_pc == $past(return_addr); endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_jc; s_take(8'h40) |=> br_taken == $past(status_val[7]) ##0
        instr_cycles == 4'h2 + {3'h0, br_taken} ##1 !instr_ready; endproperty
    a_jc: assert property (p_jc) else $error("carry jump timing wrong");
    property p_rel; s_take(8'h80) |=> next_pc == $past(pc2)
        + {{8{$past(instr_b1[7])}}, $past(instr_b1)}; endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_page; s_take(8'h01) |=> next_pc == {$past(pc2[15:11]),
        $past(instr_opcode[7:5]), $past(instr_b1)}; endproperty
    a_page: assert property (p_page) else $error("page target wrong");
    property p_nop; s_take(8'ha5) |=> instr_cycles == 4'h1 && !acc_we; endproperty
    a_nop: assert property (p_nop) else $error("spare opcode wrong");
endmodule

// [test/testbench.sv]
// Purpose: Self-checking bench for instruction lengths, clocks and targets.
// Assumes: Inputs change on the falling clock edge.
// Notes: Memory model supplies operand values.
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [7:0] instr_opcode = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00;
    logic [7:0] acc_val = 8'h00, status_val = 8'h00, src_val, dir_val, ptr_val, acc_res, ram_res;
    logic [15:0] instr_pc = 16'h1000, data_ptr_val = 16'h1234, return_addr;
    logic [15:0] next_pc, code_addr, xdata_addr;
    logic bit_val, instr_ready, instr_done, br_taken, code_rd, xdata_rd, xdata_wr, dir_special;
    logic [6:0] strb;
    logic acc_we, carry_we, carry_res, ram_we, bit_clr;
    logic [1:0] instr_len;
    logic [3:0] instr_cycles;
    logic [4:0] reg_addr, ptr_addr;
    logic [15:0] tbl [23] = '{16'he411, 16'ha511, 16'h7533, 16'h9033, 16'h9313, 16'h8313,
        16'he013, 16'hf213, 16'he612, 16'hd612, 16'hc022, 16'hd022, 16'he811, 16'hd311,
        16'hb222, 16'h1234, 16'h1123, 16'h2215, 16'h3215, 16'h0234, 16'h0123, 16'h7313,
        16'h8533};
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #50 clock = ~clock;
    mct_instr_timing i_dut (.*);
    mct_mem_model i_mem (.*);
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        int k;
        @(negedge clock);
        instr_opcode = op;
        instr_b1 = b1;
        instr_b2 = b2;
        instr_valid = 1'b1;
        @(negedge clock);
        instr_valid = 1'b0;
        // Strobes stand only while busy, so catch them half a cycle after the accept
        strb = {code_rd, xdata_rd, xdata_wr, acc_we, carry_we, ram_we, bit_clr};
        for (k = 0; k < 10 && instr_done !== 1'b1; k++) @(negedge clock);
        chk(instr_done, 1'b1);
    endtask
    task t_table;
        foreach (tbl[i]) begin
            run(tbl[i][15:8], 8'h5b, 8'h00);
            chk(instr_len, tbl[i][5:4]);
            chk(instr_cycles, tbl[i][3:0]);
        end
        $display("table test done");
    endtask
    task t_branch;
        status_val = 8'h80;
        run(8'h40, 8'h10, 8'h00);
        chk({br_taken, instr_cycles}, 5'h13);
        chk(next_pc, 16'h1012);
        status_val = 8'h00;
        run(8'h40, 8'h10, 8'h00);
        chk({br_taken, instr_cycles}, 5'h02);
        run(8'h80, 8'hfe, 8'h00);
        chk(next_pc, 16'h1000);
        run(8'hb6, 8'h20, 8'h05);
        chk(instr_cycles, 4'h5);
        run(8'hd8, 8'h5b, 8'h00);
        chk(instr_cycles, 4'h2);
        chk(ram_res, 8'h00);
        $display("branch test done");
    endtask
    task t_jump;
        run(8'h22, 8'h47, 8'h00);
        chk(next_pc, 16'h473c);
        run(8'h02, 8'hab, 8'hcd);
        chk(next_pc, 16'habcd);
        instr_pc = 16'h07fe;
        run(8'he1, 8'h34, 8'h00);
        chk(next_pc, 16'h0f34);
        status_val = 8'h18;
        run(8'he9, 8'h00, 8'h00);
        chk(reg_addr, 5'h19);
        run(8'he7, 8'h00, 8'h00);
        chk(ptr_addr, 5'h19);
        $display("jump test done");
    endtask
    task t_data;
        acc_val = 8'h3c;
        run(8'hd7, 8'h5b, 8'h00);
        chk(acc_res, 8'h31);
        chk(ram_res, 8'h0c);
        chk(strb, 7'h0a);
        run(8'h93, 8'h00, 8'h00);
        chk(code_addr, 16'h1270);
        chk(strb, 7'h40);
        run(8'h83, 8'h00, 8'h00);
        chk(code_addr, 16'h083b);
        run(8'hf3, 8'h5b, 8'h00);
        chk(xdata_addr, 16'h005c);
        chk(strb, 7'h10);
        run(8'h10, 8'ha5, 8'h00);
        chk({dir_special, instr_cycles}, 5'h14);
        chk(strb, 7'h01);
        run(8'h20, 8'h5a, 8'h00);
        chk({dir_special, br_taken, instr_cycles}, 6'h03);
        status_val = 8'h80;
        run(8'h33, 8'h00, 8'h00);
        chk({carry_res, acc_res}, 9'h079);
        chk(strb, 7'h0c);
        run(8'hb4, 8'h40, 8'h02);
        chk({carry_res, br_taken, instr_cycles}, 6'h34);
        chk(next_pc, 16'h0803);
        chk(strb, 7'h04);
        $display("data test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({instr_ready, instr_cycles}, 5'h11);
        sys_rst = 1'b0;
        t_table();
        t_branch();
        t_jump();
        t_data();
        end_of_test();
    end
endmodule
bind mct_instr_timing mct_monitor i_mon (.*);
